/* drive_map_defines.svh */
// How it works
// - Serve pair 20/70 unconfigured, or 21/71 when selected
// - Supervisor, motor, drive, assembly objects readable
// - Output bit0 drives command bit0 forward
// - Assembly 21 bit1 drives command bit1
// - Fault clear rising edge pulses command bit15
// - Network select bits accepted, no effect
// - Frequency equals RPM times poles over 120
// - Pole count captured once after boot
// - Input bit0 from status bit11
// - Alert bit always sent as zero
// - Input bit2 from status bit0
// - Assembly 71 bit3 from status bit1
// - Ready bit in Ready, Enabled, Stopping
// - Network indication bits always zero
// - At speed: running, not accelerating/decelerating
// - Assembly 71 byte1 carries supervisor state
// - Actual RPM equals Hz times 120 over poles
`ifndef DRIVE_MAP_DEFINES_SVH
`define DRIVE_MAP_DEFINES_SVH

// ==========================================================
// Register offsets
`define CONN_CFG_ADDR 12'h000
`define OUT_IMAGE_ADDR 12'h004
`define IN_IMAGE_ADDR 12'h008
`define OBJ_SEL_ADDR 12'h00C
`define OBJ_DATA_ADDR 12'h010
`define CMD_VIEW_ADDR 12'h014

// ==========================================================
// Reset values
`define CONN_CFG_RESET 1'b0
`define OUT_IMAGE_RESET 32'h0000_0000
`define OBJ_SEL_RESET 8'h00

// ==========================================================
// Field positions
`define OUT_RUN_FWD_BIT 0
`define OUT_RUN_REV_BIT 1
`define OUT_FAULT_CLR_BIT 2
`define CMD_FWD_BIT 0
`define CMD_REV_BIT 1
`define CMD_RESET_BIT 15
`define STAT_FWD_BIT 0
`define STAT_REV_BIT 1
`define STAT_ACC_BIT 9
`define STAT_DEC_BIT 10
`define STAT_ALARM_BIT 11

// ==========================================================
// Object class codes
`define CLASS_ASSEMBLY 8'h04
`define CLASS_MOTOR 8'h28
`define CLASS_SUPERVISOR 8'h29
`define CLASS_DRIVE 8'h2A

// ==========================================================
// Conversion and timing
`define SPEED_FACTOR 16'h0078
`define DIV_STEPS 6'h20

`endif

/* drive_map_pkg.sv */
package drive_map_pkg;

    typedef enum logic [7:0] {
        SUP_STARTUP = 8'b0000_0001,
        SUP_NOT_READY = 8'b0000_0010,
        SUP_READY = 8'b0000_0011,
        SUP_ENABLED = 8'b0000_0100,
        SUP_STOPPING = 8'b0000_0101,
        SUP_FAULT_STOP = 8'b0000_0110,
        SUP_FAULTED = 8'b0000_0111
    } sup_state_type;

    // Truncated quotient clamped to a 16-bit register
    function automatic logic [15:0] sat16(input logic [31:0] value);
        if (value[31:16] != 16'h0000) begin
            return 16'hFFFF;
        end
        return value[15:0];
    endfunction

endpackage

/* speed_divider.sv */
`timescale 1ns/1ps
`default_nettype none
`include "drive_map_defines.svh"

module speed_divider (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic start,
    input wire logic [31:0] dividend,
    input wire logic [15:0] divisor,
    output logic busy,
    output logic done,
    output logic [31:0] quotient
);

    logic [16:0] remainder;
    logic [5:0] steps;
    logic [16:0] trial;
    logic [15:0] heldDivisor;
    logic [31:0] heldDividend;

    assign trial = {remainder[15:0], quotient[31]};

    // ==========================================================
    // Restoring division, one quotient bit per clock
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            remainder <= 17'h0_0000;
            quotient <= 32'h0000_0000;
            steps <= 6'h00;
            busy <= 1'b0;
            done <= 1'b0;
            heldDivisor <= 16'h0000;
            heldDividend <= 32'h0000_0000;
        end else begin
            done <= 1'b0;
            if (!busy) begin
                if (start) begin
                    remainder <= 17'h0_0000;
                    quotient <= dividend;
                    heldDividend <= dividend;
                    heldDivisor <= divisor;
                    steps <= `DIV_STEPS;
                    busy <= 1'b1;
                end
            end else begin
                if (trial >= {1'b0, heldDivisor}) begin
                    remainder <= trial - {1'b0, heldDivisor};
                    quotient <= {quotient[30:0], 1'b1};
                end else begin
                    remainder <= trial;
                    quotient <= {quotient[30:0], 1'b0};
                end
                steps <= steps - 6'h01;
                if (steps == 6'h01) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end

    chk_div_latency: assert property (@(posedge clk) disable iff (sys_rst)
        (start && !busy) |-> ##33 done)
        else $error("divider result not ready after 33 cycles");

    chk_div_truncates: assert property (@(posedge clk) disable iff (sys_rst)
        (done && heldDivisor != 16'h0000) |->
        ({16'h0000, heldDividend} - {16'h0000, quotient} * {32'h0000_0000, heldDivisor})
        < {32'h0000_0000, heldDivisor})
        else $error("divider quotient not truncated correctly");

endmodule

`default_nettype wire

/* supervisor_fsm.sv */
`timescale 1ns/1ps
`default_nettype none

module supervisor_fsm (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic bootDone,
    input wire logic runRequest,
    input wire logic faultActive,
    input wire logic running,
    output var drive_map_pkg::sup_state_type state
);

    drive_map_pkg::sup_state_type next_state;

    // ==========================================================
    // Control supervisor state transitions
    always_comb begin
        next_state = state;
        unique case (state)
            drive_map_pkg::SUP_STARTUP: begin
                if (bootDone) begin
                    next_state = drive_map_pkg::SUP_NOT_READY;
                end
            end
            drive_map_pkg::SUP_NOT_READY: begin
                if (faultActive) begin
                    next_state = drive_map_pkg::SUP_FAULTED;
                end else begin
                    next_state = drive_map_pkg::SUP_READY;
                end
            end
            drive_map_pkg::SUP_READY: begin
                if (faultActive) begin
                    next_state = drive_map_pkg::SUP_FAULT_STOP;
                end else if (runRequest) begin
                    next_state = drive_map_pkg::SUP_ENABLED;
                end
            end
            drive_map_pkg::SUP_ENABLED: begin
                if (faultActive) begin
                    next_state = drive_map_pkg::SUP_FAULT_STOP;
                end else if (!runRequest) begin
                    next_state = drive_map_pkg::SUP_STOPPING;
                end
            end
            drive_map_pkg::SUP_STOPPING: begin
                if (faultActive) begin
                    next_state = drive_map_pkg::SUP_FAULT_STOP;
                end else if (runRequest) begin
                    next_state = drive_map_pkg::SUP_ENABLED;
                end else if (!running) begin
                    next_state = drive_map_pkg::SUP_READY;
                end
            end
            drive_map_pkg::SUP_FAULT_STOP: begin
                if (!running) begin
                    next_state = drive_map_pkg::SUP_FAULTED;
                end
            end
            drive_map_pkg::SUP_FAULTED: begin
                if (!faultActive) begin
                    next_state = drive_map_pkg::SUP_NOT_READY;
                end
            end
            default: begin
                next_state = drive_map_pkg::SUP_STARTUP;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= drive_map_pkg::SUP_STARTUP;
        end else begin
            state <= next_state;
        end
    end

    chk_fault_stops: assert property (@(posedge clk) disable iff (sys_rst)
        (faultActive && (state == drive_map_pkg::SUP_READY
            || state == drive_map_pkg::SUP_ENABLED
            || state == drive_map_pkg::SUP_STOPPING))
        |=> state == drive_map_pkg::SUP_FAULT_STOP)
        else $error("fault did not move supervisor to fault stop");

endmodule

`default_nettype wire

/* drive_profile_assembly_mapper.sv */
`timescale 1ns/1ps
`default_nettype none
`include "drive_map_defines.svh"

module drive_profile_assembly_mapper (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [15:0] commandWord,
    output logic [15:0] frequencyCommand,
    input wire logic [15:0] statusWord,
    input wire logic [15:0] outputFrequency,
    input wire logic [7:0] poleCountSetting
);

    // ==========================================================
    // Declarations
    logic pairSelect;
    logic [31:0] outImage;
    logic [31:0] inImage;
    logic [7:0] objectSelect;
    logic faultClearSeen;
    logic [7:0] poleCount;
    logic bootDone;
    logic [15:0] speedActual;
    logic apbAccess;
    logic apbWrite;
    logic addrKnown;
    logic [31:0] readValue;
    logic [31:0] objectData;
    logic runningAny;
    logic atSpeed;
    logic readyState;
    logic fwdDone;
    logic [31:0] fwdQuotient;
    logic revDone;
    logic [31:0] revQuotient;
    logic [31:0] fwdDividend;
    logic [31:0] revDividend;
    drive_map_pkg::sup_state_type supState;

    assign apbAccess = psel && penable && pready;
    assign apbWrite = apbAccess && pwrite;
    assign runningAny = statusWord[`STAT_FWD_BIT] || statusWord[`STAT_REV_BIT];
    assign atSpeed = runningAny && !statusWord[`STAT_ACC_BIT]
        && !statusWord[`STAT_DEC_BIT];
    assign readyState = supState == drive_map_pkg::SUP_READY
        || supState == drive_map_pkg::SUP_ENABLED
        || supState == drive_map_pkg::SUP_STOPPING;
    assign fwdDividend = {16'h0000, outImage[31:16]} * {24'h00_0000, poleCount};
    assign revDividend = {16'h0000, outputFrequency} * {16'h0000, `SPEED_FACTOR};

    // ==========================================================
    // Pole count capture after reset release
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            poleCount <= 8'h00;
            bootDone <= 1'b0;
        end else if (!bootDone) begin
            poleCount <= poleCountSetting;
            bootDone <= 1'b1;
        end
    end

    // ==========================================================
    // Register writes
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pairSelect <= `CONN_CFG_RESET;
            outImage <= `OUT_IMAGE_RESET;
            objectSelect <= `OBJ_SEL_RESET;
        end else if (apbWrite) begin
            unique case (paddr)
                `CONN_CFG_ADDR: pairSelect <= pwdata[0];
                `OUT_IMAGE_ADDR: outImage <= pwdata;
                `OBJ_SEL_ADDR: objectSelect <= pwdata[7:0];
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // Command word toward the inverter
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            commandWord <= 16'h0000;
            faultClearSeen <= 1'b0;
        end else begin
            faultClearSeen <= outImage[`OUT_FAULT_CLR_BIT];
            // Select bits 5 and 6 and byte 1 are never looked at
            commandWord <= 16'h0000;
            commandWord[`CMD_FWD_BIT] <= outImage[`OUT_RUN_FWD_BIT];
            commandWord[`CMD_REV_BIT] <= pairSelect && outImage[`OUT_RUN_REV_BIT];
            commandWord[`CMD_RESET_BIT] <= outImage[`OUT_FAULT_CLR_BIT]
                && !faultClearSeen;
        end
    end

    // ==========================================================
    // Speed conversions
    speed_divider rpmToHz (
        .clk(clk),
        .sys_rst(sys_rst),
        .start(bootDone),
        .dividend(fwdDividend),
        .divisor(`SPEED_FACTOR),
        .busy(),
        .done(fwdDone),
        .quotient(fwdQuotient)
    );

    speed_divider hzToRpm (
        .clk(clk),
        .sys_rst(sys_rst),
        .start(bootDone),
        .dividend(revDividend),
        .divisor({8'h00, poleCount}),
        .busy(),
        .done(revDone),
        .quotient(revQuotient)
    );

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            frequencyCommand <= 16'h0000;
        end else if (fwdDone) begin
            frequencyCommand <= drive_map_pkg::sat16(fwdQuotient);
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            speedActual <= 16'h0000;
        end else if (revDone) begin
            speedActual <= drive_map_pkg::sat16(revQuotient);
        end
    end

    // ==========================================================
    // Supervisor state machine
    supervisor_fsm supervisor (
        .clk(clk),
        .sys_rst(sys_rst),
        .bootDone(bootDone),
        .runRequest(commandWord[`CMD_FWD_BIT] || commandWord[`CMD_REV_BIT]),
        .faultActive(statusWord[`STAT_ALARM_BIT]),
        .running(runningAny),
        .state(supState)
    );

    // ==========================================================
    // Input assembly image
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            inImage <= 32'h0000_0000;
        end else begin
            inImage <= 32'h0000_0000;
            inImage[0] <= statusWord[`STAT_ALARM_BIT];
            inImage[2] <= statusWord[`STAT_FWD_BIT];
            inImage[3] <= pairSelect && statusWord[`STAT_REV_BIT];
            inImage[4] <= pairSelect && readyState;
            inImage[7] <= pairSelect && atSpeed;
            inImage[15:8] <= pairSelect ? supState : 8'h00;
            inImage[31:16] <= speedActual;
        end
    end

    // ==========================================================
    // Object attribute access
    always_comb begin
        unique case (objectSelect)
            `CLASS_ASSEMBLY: objectData = inImage;
            `CLASS_MOTOR: objectData = {24'h00_0000, poleCount};
            `CLASS_SUPERVISOR: objectData = {24'h00_0000, supState};
            `CLASS_DRIVE: objectData = {speedActual, frequencyCommand};
            default: objectData = 32'h0000_0000;
        endcase
    end

    // ==========================================================
    // APB read path and answer
    always_comb begin
        addrKnown = 1'b1;
        readValue = 32'h0000_0000;
        unique case (paddr)
            `CONN_CFG_ADDR: readValue = {31'h0000_0000, pairSelect};
            `OUT_IMAGE_ADDR: readValue = outImage;
            `IN_IMAGE_ADDR: readValue = inImage;
            `OBJ_SEL_ADDR: readValue = {24'h00_0000, objectSelect};
            `OBJ_DATA_ADDR: readValue = objectData;
            `CMD_VIEW_ADDR: readValue = {frequencyCommand, commandWord};
            default: addrKnown = 1'b0;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addrKnown;
            prdata <= (psel && !penable && !pwrite) ? readValue : 32'h0000_0000;
        end
    end

    // ==========================================================
    // Checks
    chk_fwd_copy: assert property (@(posedge clk) disable iff (sys_rst)
        (apbWrite && paddr == `OUT_IMAGE_ADDR)
        |=> ##1 commandWord[`CMD_FWD_BIT] == $past(pwdata[0], 2))
        else $error("forward run not copied to command word");

    chk_rev_gated: assert property (@(posedge clk) disable iff (sys_rst)
        $past(!pairSelect) |-> !commandWord[`CMD_REV_BIT])
        else $error("reverse run passed with assembly 20");

    chk_reset_edge: assert property (@(posedge clk) disable iff (sys_rst)
        commandWord[`CMD_RESET_BIT] |->
        ($past(outImage[`OUT_FAULT_CLR_BIT], 1) && !$past(outImage[`OUT_FAULT_CLR_BIT], 2))
        ##1 !commandWord[`CMD_RESET_BIT])
        else $error("fault reset pulse without rising edge");

    chk_pole_frozen: assert property (@(posedge clk) disable iff (sys_rst)
        $past(bootDone) |-> $stable(poleCount))
        else $error("pole count changed after boot");

    chk_fault_bit: assert property (@(posedge clk) disable iff (sys_rst)
        inImage[0] == $past(statusWord[`STAT_ALARM_BIT]))
        else $error("fault bit does not follow status");

    chk_zero_bits: assert property (@(posedge clk) disable iff (sys_rst)
        (inImage[1] == 1'b0 && inImage[6:5] == 2'b00)
        and ($past(!pairSelect) |-> inImage[15:3] == 13'h0000))
        else $error("unused input bits not zero");

    chk_at_speed: assert property (@(posedge clk) disable iff (sys_rst)
        inImage[7] |-> $past(pairSelect && runningAny
        && !statusWord[`STAT_ACC_BIT] && !statusWord[`STAT_DEC_BIT]))
        else $error("at speed set while not at speed");

    chk_ready_bit: assert property (@(posedge clk) disable iff (sys_rst)
        $past(pairSelect) |-> inImage[4] == $past(readyState))
        else $error("ready bit does not match supervisor state");

    chk_apb_answer: assert property (@(posedge clk) disable iff (sys_rst)
        (psel && !penable) |=> pready ##1 !pready)
        else $error("apb answer not given in one cycle");

endmodule

`default_nettype wire

/* inverter_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Inverter side: status, output frequency and pole setting
module inverter_model (
    input wire logic clk,
    input wire logic [15:0] commandWord,
    output logic [15:0] statusWord,
    output logic [15:0] outputFrequency,
    output logic [7:0] poleCountSetting
);
    logic [15:0] statusReg = 16'h0000;
    logic [15:0] freqReg = 16'h0000;
    logic [7:0] poleReg = 8'h04;
    int resetPulses = 0;
    int longestPulse = 0;
    int runLen = 0;

    assign statusWord = statusReg;
    assign outputFrequency = freqReg;
    assign poleCountSetting = poleReg;

    // ==========================================================
    // Counts reset pulses and their widths
    always @(posedge clk) begin
        if (commandWord[15] === 1'b1) begin
            runLen = runLen + 1;
            if (runLen == 1) begin
                resetPulses = resetPulses + 1;
            end
            if (runLen > longestPulse) begin
                longestPulse = runLen;
            end
        end else begin
            runLen = 0;
        end
    end
endmodule
`default_nettype wire

/* drive_profile_assembly_mapper_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module drive_profile_assembly_mapper_tb_top;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic [15:0] commandWord, frequencyCommand, statusWord, outputFrequency;
    logic [7:0] poleCountSetting;
    int errors = 0;
    int n_compared = 0;

    always #12.5 clk = ~clk;

    drive_profile_assembly_mapper uut (.clk(clk), .sys_rst(sys_rst), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .commandWord(commandWord),
        .frequencyCommand(frequencyCommand), .statusWord(statusWord),
        .outputFrequency(outputFrequency), .poleCountSetting(poleCountSetting));

    inverter_model inv (.clk(clk), .commandWord(commandWord), .statusWord(statusWord),
        .outputFrequency(outputFrequency), .poleCountSetting(poleCountSetting));

    // ==========================================================
    // Reporting
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expected);
        n_compared++;
        if (seen !== expected) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, expected, seen);
        end
    endtask

    // ==========================================================
    // APB master
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge clk);
            if (pready === 1'b1) begin
                break;
            end
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 20) begin
            $display("CHECK FAILED pready expected 1 seen timeout");
            errors++;
            results();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(a, 1'b1, d, rd, err);
    endtask

    task automatic rdChk(input string what, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        apb(a, 1'b0, 32'h0000_0000, rd, err);
        check(what, rd, exp);
    endtask

    // Reads until the masked value matches or the bound runs out
    task automatic pollReg(input string what, input logic [11:0] a, input logic [31:0] mask,
                           input logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        for (int k = 0; k < 60; k++) begin
            apb(a, 1'b0, 32'h0000_0000, rd, err);
            if ((rd & mask) === exp) begin
                break;
            end
        end
        check(what, rd & mask, exp);
        if ((rd & mask) !== exp) begin
            results();
        end
    endtask

    function automatic logic [31:0] expImage(input logic pair, input logic [15:0] st,
                                             input logic [7:0] state, input logic [15:0] rpm);
        logic run, rdy;
        logic [7:0] b0;
        run = st[0] | st[1];
        rdy = (state == 8'h03) || (state == 8'h04) || (state == 8'h05);
        if (pair) begin
            b0 = {run & ~st[9] & ~st[10], 2'h0, rdy, st[1], st[0], 1'b0, st[11]};
        end else begin
            b0 = {5'h00, st[0], 1'b0, st[11]};
        end
        return {rpm, (pair ? state : 8'h00), b0};
    endfunction

    // ==========================================================
    // Scenarios
    task automatic testResetValues();
        logic [31:0] rd;
        logic err;
        rdChk("conn cfg reset", 12'h000, 32'h0000_0000);
        rdChk("out image reset", 12'h004, 32'h0000_0000);
        rdChk("obj sel reset", 12'h00C, 32'h0000_0000);
        apb(12'h018, 1'b0, 32'h0000_0000, rd, err);
        check("unmapped error", {31'h0000_0000, err}, 32'h0000_0001);
        check("unmapped data", rd, 32'h0000_0000);
    endtask

    task automatic testRunBits();
        for (int p = 0; p < 2; p++) begin
            wr(12'h000, p);
            wr(12'h004, 32'h0000_FF63);
            repeat (4) @(posedge clk);
            check("command run bits", commandWord, p ? 32'h0000_0003 : 32'h0000_0001);
            check("select bits inert", commandWord & 16'h7FFC, 32'h0000_0000);
            wr(12'h004, 32'h0000_0000);
            repeat (4) @(posedge clk);
            check("command cleared", commandWord, 32'h0000_0000);
        end
    endtask

    task automatic testFaultClear();
        wr(12'h004, 32'h0000_0004);
        repeat (4) @(posedge clk);
        check("reset pulse on rise", inv.resetPulses, 32'h0000_0001);
        wr(12'h004, 32'h0000_0004);
        repeat (4) @(posedge clk);
        check("no pulse on level", inv.resetPulses, 32'h0000_0001);
        wr(12'h004, 32'h0000_0000);
        wr(12'h004, 32'h0000_0004);
        repeat (4) @(posedge clk);
        check("second rise pulses", inv.resetPulses, 32'h0000_0002);
        check("pulse one cycle", inv.longestPulse, 32'h0000_0001);
        wr(12'h004, 32'h0000_0000);
    endtask

    task automatic testSpeedRef();
        wr(12'h004, {16'd1800, 16'h0000});
        pollReg("freq 1800 rpm", 12'h014, 32'hFFFF_0000, {16'd60, 16'h0000});
        wr(12'h004, {16'd1001, 16'h0000});
        pollReg("freq truncated", 12'h014, 32'hFFFF_0000, {16'd33, 16'h0000});
        check("freq port", frequencyCommand, 32'd33);
    endtask

    task automatic testInputs();
        logic [15:0] sts [5] = '{16'h0001, 16'h0201, 16'h0402, 16'h0002, 16'h0003};
        logic [7:0] codes [5] = '{8'h04, 8'h28, 8'h29, 8'h2A, 8'h55};
        logic [31:0] objExp [5];
        inv.freqReg <= 16'd50;
        wr(12'h000, 32'h0000_0001);
        pollReg("speed actual", 12'h008, 32'hFFFF_0000, {16'd1500, 16'h0000});
        for (int p = 1; p >= 0; p--) begin
            wr(12'h000, p);
            for (int i = 0; i < 5; i++) begin
                inv.statusReg <= sts[i];
                repeat (3) @(posedge clk);
                rdChk("input image", 12'h008, expImage(p, sts[i], 8'h03, 16'd1500));
            end
        end
        objExp = '{expImage(1'b0, 16'h0003, 8'h03, 16'd1500), 32'd4, 32'd3,
                   {16'd1500, 16'd33}, 32'h0000_0000};
        for (int i = 0; i < 5; i++) begin
            wr(12'h00C, codes[i]);
            rdChk("object data", 12'h010, objExp[i]);
        end
    endtask

    task automatic testPoleReboot();
        inv.poleReg <= 8'h06;
        repeat (100) @(posedge clk);
        rdChk("poles held freq", 12'h014, {16'd33, 16'h0000});
        rdChk("poles held speed", 12'h008, expImage(1'b0, 16'h0003, 8'h03, 16'd1500));
        inv.statusReg <= 16'h0000;
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        wr(12'h004, {16'd1001, 16'h0000});
        pollReg("freq new poles", 12'h014, 32'hFFFF_0000, {16'd50, 16'h0000});
        pollReg("speed new poles", 12'h008, 32'hFFFF_0000, {16'd1000, 16'h0000});
    endtask

    task automatic testAlarm();
        wr(12'h000, 32'h0000_0001);
        inv.statusReg <= 16'h0800;
        pollReg("faulted image", 12'h008, 32'h0000_FFFF, 32'h0000_0701);
        rdChk("faulted ready", 12'h008, expImage(1'b1, 16'h0800, 8'h07, 16'd1000));
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        testResetValues();
        testRunBits();
        testFaultClear();
        testSpeedRef();
        testInputs();
        testPoleReboot();
        testAlarm();
        results();
    end
endmodule
`default_nettype wire
